// ===== core/bsp_pkg.sv
// Constants, register map and carrier types of the byte serial port.
// Assumes a 10 MHz system clock and an AXI4-Lite master for software access.

package bsp_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] REG_RBUF = 8'h00;
  localparam logic [7:0] REG_WBUF = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0c;
  localparam logic [7:0] REG_ISR = 8'h10;
  localparam logic [7:0] REG_IMR = 8'h14;

  // ==========================================================
  // Field positions and reset values
  localparam int STAT_RX_FULL = 0;
  localparam int STAT_RX_IRQ = 1;
  localparam int ISR_SERIAL = 2;
  localparam int IMR_SERIAL = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] IMR_RESET = 8'h00;
  localparam logic [7:0] BUF_RESET = 8'h00;

  // ==========================================================
  // Rate codes, byte length, timing
  localparam logic [2:0] RATE_DIV_LAST = 3'h4;
  localparam logic [2:0] RATE_SLV_SEL = 3'h5;
  localparam logic [2:0] RATE_SLV_NOSEL = 3'h6;
  localparam logic [2:0] RATE_TIMER = 3'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int CLK_HZ = 10_000_000;
  localparam int MAX_BIT_HZ = 8_000_000;

  // ==========================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic edge_select;
    logic serial_enable;
    logic read_overflow;
    logic shift_go;
    logic spare;
    logic [2:0] rate_select;
  } bsp_ctrl_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MASTER = 2'b01,
    ST_SLAVE = 2'b10
  } bsp_state_type;

endpackage

// ===== core/bsp_serial_port.sv
// Byte serial port, master or slave, with an AXI4-Lite register slave.
// Assumes pins already synchronous to clk; slave sck must stay below clk/2.
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module bsp_serial_port import bsp_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int SYS_HZ = CLK_HZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial pins
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire logic ss_n,
  // Timer tick for the timer-clocked master rate
  input wire logic tmr1_tick,
  // Interrupt request to the core
  output logic irq
);

  // ==========================================================
  // Elaboration checks
  initial begin
    if (ADDR_W < 5 || ADDR_W > 8) begin
      $error("ADDR_W must be 5 to 8");
    end
    if (SYS_HZ / 2 > MAX_BIT_HZ) begin
      $error("Fastest divider would exceed the bit clock limit");
    end
  end

  // ==========================================================
  // Registers and state
  bsp_ctrl_type ctrl;
  bsp_state_type state;
  logic [7:0] read_buffer;
  logic [7:0] write_buffer;
  logic [7:0] shift_register;
  logic [7:0] interrupt_enable_mask;
  logic rx_buffer_full;
  logic rx_full_irq_flag;
  logic serial_irq_flag;
  logic [3:0] bit_cnt;
  logic [4:0] div_cnt;
  logic sck_prev;
  logic done;
  logic [7:0] aw_addr;
  logic [7:0] w_data;
  logic w_lane;

  // ==========================================================
  // Decoded mode
  logic is_master;
  logic is_slave;
  logic slave_active;
  logic wr_do;
  logic rd_do;
  logic [7:0] rd_addr;
  logic wr_wbuf;
  logic wr_go;
  logic rd_rbuf;
  logic sck_rise;
  logic sck_fall;
  logic sample_edge;
  logic out_edge;
  logic tick;
  logic [4:0] div_load;

  assign is_master = (ctrl.rate_select <= RATE_DIV_LAST) ||
                     (ctrl.rate_select == RATE_TIMER);
  assign is_slave = !is_master;
  // Select matters only for the selected-slave code; master ignores it
  assign slave_active = (ctrl.rate_select == RATE_SLV_NOSEL) ||
                        !ss_n;

  assign wr_do = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign rd_do = s_axi_arvalid && s_axi_arready;
  assign rd_addr = 8'(s_axi_araddr);
  // Writes to the data buffer are dropped while a byte is moving
  assign wr_wbuf = wr_do && w_lane && (aw_addr == REG_WBUF) &&
                   !ctrl.shift_go && (state == ST_IDLE);
  assign wr_go = wr_do && w_lane && (aw_addr == REG_CTRL) &&
                 w_data[4];
  assign rd_rbuf = rd_do && (rd_addr == REG_RBUF);

  // Clock select: external edges for slave, divider or timer tick for master
  assign sck_rise = sck_in && !sck_prev;
  assign sck_fall = !sck_in && sck_prev;
  assign sample_edge = ctrl.edge_select ? sck_rise : sck_fall;
  assign out_edge = ctrl.edge_select ? sck_fall : sck_rise;

  // Half period of 2^code clocks gives clk/2 .. clk/32
  assign div_load = 5'(5'h01 << ctrl.rate_select[2:0]) - 5'h01;
  assign tick = (ctrl.rate_select == RATE_TIMER) ? tmr1_tick :
                (div_cnt == 5'h00);

  // ==========================================================
  // AXI write path
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 8'h00;
      w_lane <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr <= 8'(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr[1:0] == 2'b00 && aw_addr <= REG_IMR) ?
                       RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // AXI read path
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (rd_do) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (rd_addr)
          REG_RBUF: s_axi_rdata <= {24'h00_0000, read_buffer};
          REG_WBUF: s_axi_rdata <= {24'h00_0000, write_buffer};
          REG_STAT: begin
            s_axi_rdata <= {30'h0000_0000, rx_full_irq_flag,
                            rx_buffer_full};
          end
          REG_CTRL: s_axi_rdata <= {24'h00_0000, ctrl};
          // Status reads back masked by the enables
          REG_ISR: begin
            s_axi_rdata <= {29'h0000_0000, serial_irq_flag &
                            interrupt_enable_mask[IMR_SERIAL], 2'b00};
          end
          REG_IMR: s_axi_rdata <= {24'h00_0000, interrupt_enable_mask};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Control register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= bsp_ctrl_type'(CTRL_RESET);
    end else begin
      if (wr_do && w_lane && aw_addr == REG_CTRL) begin
        ctrl.edge_select <= w_data[7];
        ctrl.serial_enable <= w_data[6];
        ctrl.rate_select <= w_data[2:0];
        // Overflow is only cleared by software, never set
        if (!w_data[5]) begin
          ctrl.read_overflow <= 1'b0;
        end
      end
      // Hardware alone lowers shift-go; software can only raise it
      if (wr_go && state == ST_IDLE) begin
        ctrl.shift_go <= 1'b1;
      end
      if (done) begin
        ctrl.shift_go <= 1'b0;
      end
      // Set wins over a clear in the same cycle
      if (done && is_slave && rx_buffer_full) begin
        ctrl.read_overflow <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Data buffers and mask
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      write_buffer <= BUF_RESET;
      read_buffer <= BUF_RESET;
      interrupt_enable_mask <= IMR_RESET;
    end else begin
      if (wr_wbuf) begin
        write_buffer <= w_data;
      end
      // Unread byte is overwritten; software must read in time
      if (done) begin
        read_buffer <= shift_register;
      end
      if (wr_do && w_lane && aw_addr == REG_IMR) begin
        interrupt_enable_mask <= w_data;
      end
    end
  end

  // ==========================================================
  // Sticky flags: hardware sets, software clears, set wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_buffer_full <= 1'b0;
      rx_full_irq_flag <= 1'b0;
      serial_irq_flag <= 1'b0;
    end else begin
      if (done) begin
        rx_buffer_full <= 1'b1;
      end else if (rd_rbuf) begin
        rx_buffer_full <= 1'b0;
      end else if (wr_do && w_lane && aw_addr == REG_STAT &&
                   !w_data[STAT_RX_FULL]) begin
        rx_buffer_full <= 1'b0;
      end
      if (done) begin
        rx_full_irq_flag <= 1'b1;
      end else if (wr_do && w_lane && aw_addr == REG_STAT &&
                   !w_data[STAT_RX_IRQ]) begin
        rx_full_irq_flag <= 1'b0;
      end
      if (done) begin
        serial_irq_flag <= 1'b1;
      end else if (wr_do && w_lane && aw_addr == REG_ISR &&
                   !w_data[ISR_SERIAL]) begin
        serial_irq_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Interrupt line
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= serial_irq_flag && interrupt_enable_mask[IMR_SERIAL];
    end
  end

  // ==========================================================
  // Pin drivers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sck_oe <= 1'b0;
      sdo_oe <= 1'b0;
      sck_prev <= 1'b0;
    end else begin
      sck_prev <= sck_in;
      sck_oe <= ctrl.serial_enable && is_master;
      // Deselected slave releases its data pin
      sdo_oe <= ctrl.serial_enable && (is_master || slave_active);
    end
  end

  // ==========================================================
  // Rate divider
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt <= 5'h00;
    end else if (state != ST_MASTER || div_cnt == 5'h00) begin
      div_cnt <= div_load;
    end else begin
      div_cnt <= div_cnt - 5'h01;
    end
  end

  // ==========================================================
  // Shift engine
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      shift_register <= BUF_RESET;
      bit_cnt <= 4'h0;
      sdo <= 1'b0;
      sck_out <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        ST_IDLE: begin
          bit_cnt <= 4'h0;
          // Idle level sits opposite the sampling edge
          sck_out <= !ctrl.edge_select;
          if (wr_wbuf) begin
            shift_register <= w_data;
            sdo <= w_data[7];
          end else if (ctrl.shift_go && ctrl.serial_enable && !done) begin
            shift_register <= write_buffer;
            sdo <= write_buffer[7];
            state <= is_master ? ST_MASTER : ST_SLAVE;
          end
        end
        ST_MASTER: begin
          if (!ctrl.serial_enable) begin
            state <= ST_IDLE;
          end else if (tick) begin
            sck_out <= !sck_out;
            if (sck_out == !ctrl.edge_select) begin
              shift_register <= {shift_register[6:0], sdi};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (bit_cnt == BYTE_BITS) begin
              state <= ST_IDLE;
              done <= 1'b1;
            end else begin
              sdo <= shift_register[7];
            end
          end
        end
        ST_SLAVE: begin
          if (!ctrl.serial_enable) begin
            state <= ST_IDLE;
          end else if (!slave_active) begin
            bit_cnt <= 4'h0;
          end else if (sample_edge) begin
            shift_register <= {shift_register[6:0], sdi};
            if (bit_cnt == BYTE_BITS - 4'h1) begin
              state <= ST_IDLE;
              done <= 1'b1;
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end else if (out_edge && bit_cnt != 4'h0) begin
            sdo <= shift_register[7];
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ===== test/bsp_chk_sva.sv
// Checker for the register bus answers of the serial port.
// Assumes it is bound onto bsp_serial_port and sees only its ports.
`timescale 1ns/1ps

module bsp_chk import bsp_pkg::*; #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial side
  input wire logic sck_oe,
  input wire logic irq
);
  logic wgo;
  logic rgo;
  assign wgo = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rgo = s_axi_arvalid && s_axi_arready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // Answers
  // Commit cycle sits between the handshake and the answer
  a_write_answer: assert property (wgo |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  a_unmapped_write: assert property (wgo && s_axi_awaddr > ADDR_W'(REG_IMR)
    |-> ##2 s_axi_bresp == RESP_SLVERR) else $error("bad write answer");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_write_free: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not freed");
  a_read_answer: assert property (rgo |=> s_axi_rvalid)
    else $error("read not answered");
  a_unmapped_read: assert property (rgo && s_axi_araddr > ADDR_W'(REG_IMR)
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
  a_mapped_read: assert property (rgo && s_axi_araddr <= ADDR_W'(REG_IMR)
    && s_axi_araddr[1:0] == 2'h0 |=> s_axi_rresp == RESP_OKAY) else $error("bad read code");
  a_read_free: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid
    ##0 s_axi_arready) else $error("read not freed");
  a_byte_read: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0
    && !s_axi_arready) else $error("read word malformed");
  c_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  c_master: cover property ($rose(sck_oe));
  c_irq: cover property ($rose(irq));
endmodule

bind bsp_serial_port bsp_chk #(.ADDR_W(ADDR_W)) chk_u (.clk, .rstn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .sck_oe, .irq);

// ===== test/bsp_far_end.sv
// Far-end serial device: slave when the port is master, master otherwise.
// Assumes all pins sampled on the system clock.
`timescale 1ns/1ps

module bsp_far_end (
  // Clock
  input wire logic clk,
  // Link
  input wire logic sck,
  input wire logic sdo,
  input wire logic es,
  output logic sck_drv,
  output logic sdi,
  output logic ss_n
);
  logic prev = 1'b0;
  logic m_on = 1'b0;
  logic m_sdi = 1'b0;
  logic [7:0] tx = 8'h00;
  logic [7:0] rx = 8'h00;
  initial sck_drv = 1'b0;
  initial ss_n = 1'b1;
  // Shows the next bit as soon as the shift edge appears, so a clk/2 master
  // does not sample the old bit while this model is still one clk behind
  assign sdi = m_on ? m_sdi : (sck != prev && sck != es) ? tx[6] : tx[7];
  // Slave role
  always @(posedge clk) begin
    prev <= sck;
    if (!m_on && sck != prev && sck == es) rx <= {rx[6:0], sdo};
    if (!m_on && sck != prev && sck != es) tx <= {tx[6:0], ~tx[7]};
  end
  // Waits out the edge that a new idle clock level causes, so the shift
  // and the load never land on the same clk edge
  task load(input logic [7:0] b);
    repeat (2) @(posedge clk);
    tx <= b;
  endtask
  // Master role, 8 clk per bit keeps the bit clock far below the limit
  task xfer(input logic [7:0] b, input logic sel, output logic [7:0] got);
    @(posedge clk);
    m_on <= 1'b1;
    ss_n <= !sel;
    for (int i = 7; i >= 0; i--) begin
      m_sdi <= b[i];
      repeat (4) @(posedge clk);
      sck_drv <= 1'b1;
      got[i] = sdo;
      repeat (4) @(posedge clk);
      sck_drv <= 1'b0;
    end
    repeat (4) @(posedge clk);
    ss_n <= 1'b1;
    m_on <= 1'b0;
  endtask
endmodule

// ===== test/tb_byte_serial_port_master_slave.sv
// Testbench of the byte serial port: register bus, master and slave transfers.
// Assumes the far-end model and the bound checker.
`timescale 1ns/1ps

module tb_byte_serial_port_master_slave import bsp_pkg::*; ;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic tick = 1'b0, es = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, sck_out, sck_oe, sdo, sdo_oe, irq;
  logic f_sck, f_sdi, f_ss_n;
  logic [1:0] bresp, rresp, bq, rq;
  logic [1:0] tc = 2'h0;
  logic [31:0] rdata;
  int failures = 0, compares = 0, cycles = 0, hi = 0, last_hi = 0;
  // Pull-up on the data line when nobody drives it
  wire sck_w = sck_oe ? sck_out : f_sck;
  wire sdo_w = sdo_oe ? sdo : 1'b1;
  always #50 clk = ~clk;

  bsp_serial_port #(.ADDR_W(8)) dut_u (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sck_in(sck_w),
    .sck_out(sck_out), .sck_oe(sck_oe), .sdi(f_sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .ss_n(f_ss_n), .tmr1_tick(tick), .irq(irq));
  bsp_far_end far_u (.clk(clk), .sck(sck_w), .sdo(sdo_w), .es(es), .sck_drv(f_sck),
    .sdi(f_sdi), .ss_n(f_ss_n));

  // ==========================================================
  // Timer tick every 3 clk, clock high-time meter, timeout
  always @(posedge clk) begin
    cycles <= cycles + 1;
    tc <= (tc == 2'h2) ? 2'h0 : tc + 2'h1;
    tick <= (tc == 2'h2);
    if (sck_out) hi <= hi + 1;
    else if (hi != 0) begin
      last_hi <= hi;
      hi <= 0;
    end
    if (cycles == 20000) begin
      failures = failures + 1;
      close_out();
    end
  end

  task close_out();
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bq = bresp;
    bready <= 1'b0;
  endtask
  task axr(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    rq = rresp;
    rready <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    axr(a, d);
    check(d, exp);
  endtask

  // ==========================================================
  // Scenarios
  task t_reset();
    rd_chk(REG_CTRL, {24'h0, CTRL_RESET});
    rd_chk(REG_IMR, {24'h0, IMR_RESET});
    rd_chk(REG_RBUF, {24'h0, BUF_RESET});
    rd_chk(REG_STAT, 32'h0);
    rd_chk(8'h20, 32'h0);
    check({30'h0, rq}, {30'h0, RESP_SLVERR});
    axw(8'h24, 32'h1);
    check({30'h0, bq}, {30'h0, RESP_SLVERR});
    axw(REG_IMR, 32'hff);
    rd_chk(REG_IMR, 32'hff);
  endtask
  task t_master(input logic [2:0] code, input logic e, input logic [7:0] tx,
    input logic [7:0] sl, input int half, input logic mk);
    logic [31:0] d;
    axw(REG_IMR, {28'h0, 1'b1, mk, 2'b11});
    es <= e;
    axw(REG_CTRL, {24'h0, e, 4'b1000, code});
    far_u.load(sl);
    axw(REG_WBUF, {24'h0, tx});
    axw(REG_CTRL, {24'h0, e, 4'b1010, code});
    if (code == RATE_DIV_LAST) begin
      axw(REG_WBUF, 32'h77);
      rd_chk(REG_WBUF, {24'h0, tx});
      rd_chk(REG_CTRL, {24'h0, e, 4'b1010, code});
    end
    do axr(REG_CTRL, d); while (d[4]);
    check(d, {24'h0, e, 4'b1000, code});
    check({24'h0, far_u.rx}, {24'h0, tx});
    check(32'(last_hi), 32'(half));
    rd_chk(REG_STAT, 32'h3);
    rd_chk(REG_ISR, {29'h0, mk, 2'h0});
    check({31'h0, irq}, {31'h0, mk});
    rd_chk(REG_RBUF, {24'h0, sl});
    rd_chk(REG_STAT, 32'h2);
    axw(REG_STAT, 32'h0);
    axw(REG_ISR, 32'h0);
    rd_chk(REG_ISR, 32'h0);
    check({31'h0, irq}, 32'h0);
  endtask
  task t_slave(input logic [2:0] code, input logic sel, input logic [7:0] mtx,
    input logic [7:0] dtx, input logic rd, input logic ov, input logic done);
    logic [31:0] d;
    logic [7:0] got;
    axw(REG_WBUF, {24'h0, dtx});
    axw(REG_CTRL, {24'h0, 5'b11010, code});
    far_u.xfer(mtx, sel, got);
    repeat (4) @(posedge clk);
    axr(REG_CTRL, d);
    check(d, {24'h0, 2'b11, ov, !done, 1'b0, code});
    if (done) check({24'h0, got}, {24'h0, dtx});
    else check({24'h0, got}, 32'hff);
    if (rd) rd_chk(REG_RBUF, {24'h0, mtx});
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_master(3'h0, 1'b1, 8'ha5, 8'h3c, 1, 1'b0);
    t_master(3'h1, 1'b0, 8'h5a, 8'hc3, 2, 1'b1);
    t_master(3'h2, 1'b1, 8'h81, 8'h7e, 4, 1'b1);
    t_master(3'h3, 1'b1, 8'h01, 8'h80, 8, 1'b1);
    t_master(3'h4, 1'b1, 8'hf0, 8'h0f, 16, 1'b1);
    t_master(RATE_TIMER, 1'b1, 8'h96, 8'h69, 3, 1'b1);
    t_slave(RATE_SLV_NOSEL, 1'b0, 8'hc5, 8'h3a, 1'b1, 1'b0, 1'b1);
    t_slave(RATE_SLV_NOSEL, 1'b0, 8'h11, 8'h22, 1'b0, 1'b0, 1'b1);
    t_slave(RATE_SLV_NOSEL, 1'b0, 8'h44, 8'h88, 1'b1, 1'b1, 1'b1);
    axw(REG_CTRL, 32'h0);
    t_slave(RATE_SLV_SEL, 1'b0, 8'h0f, 8'h55, 1'b0, 1'b0, 1'b0);
    t_slave(RATE_SLV_SEL, 1'b1, 8'h0f, 8'h55, 1'b1, 1'b0, 1'b1);
    close_out();
  end
endmodule
